// ---- common/rx_frame_check_params.svh ----
`ifndef RX_FRAME_CHECK_PARAMS_SVH
`define RX_FRAME_CHECK_PARAMS_SVH

// register word indices, byte address is four times the index
`define IDX_CRC_CFG     6'h12
`define IDX_RX_STATUS   6'h13
`define IDX_IRQ_STATUS  6'h20
`define IDX_IRQ_MASK    6'h21
`define IDX_RX_CTRL     6'h22

`define CFG_RESET       32'h0000_0000
`define CFG_WMASK       32'hffff_0fff
`define STATUS_RESET    32'h0000_0000
`define CTRL_RESET      2'h0
`define IRQ_RESET       4'h0

// interrupt event bit positions
`define IRQ_BIT_DONE    0
`define IRQ_BIT_COLL    1
`define IRQ_BIT_PROTO   2
`define IRQ_BIT_INTEG   3

// control register bit positions
`define CTRL_BIT_MULTI  0
`define CTRL_BIT_REVPAR 1

`define PRESET_000      16'h0000
`define PRESET_001      16'h6363
`define PRESET_010      16'ha671
`define PRESET_011      16'hffff
`define PRESET_100      16'h0012
`define PRESET_101      16'he012

`define POLY16_REFL     16'h8408
`define POLY5_REFL      5'h12
`define RESIDUE16_INV   16'hf0b8
`define RESIDUE5_INV    5'h18
`define COLL_POS_MAX    12'h07f

`endif

// ---- common/rx_frame_check_pkg.sv ----
`default_nettype none
package rx_frame_check_pkg;

  typedef struct packed {
    logic [15:0] preset_value;
    logic [3:0]  rfu;
    logic        parity_odd;
    logic        parity_en;
    logic        keep_after_coll;
    logic [2:0]  bit_align;
    logic [2:0]  preset_sel;
    logic        crc5;
    logic        check_invert;
    logic        check_en;
  } crc_cfg_t;

  typedef struct packed {
    logic [5:0] rfu;
    logic [6:0] first_collision_position;
    logic       collision;
    logic       protocol_err;
    logic       integrity_err;
    logic [2:0] last_bits;
    logic [3:0] frames;
    logic [8:0] bytes;
  } rx_status_t;

  typedef struct packed {
    logic valid;
    logic data;
    logic coll;
  } rx_bit_t;

  typedef enum logic [1:0] {MODE_TYPE_A, MODE_TYPE_B, MODE_FAST} mode_t;

  typedef enum logic {ST_IDLE, ST_RECV} rx_state_t;

endpackage
`default_nettype wire

// ---- verilog/rx_crc_engine.sv ----
`default_nettype none
`include "rx_frame_check_params.svh"
module rx_crc_engine
  import rx_frame_check_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic        i_load,
  input  wire logic [15:0] i_preset,
  input  wire logic        i_crc5,
  input  wire logic        i_bit_valid,
  input  wire logic        i_bit,
  output logic      [15:0] o_crc
);

  logic [15:0] crc_q;
  logic [15:0] crc_d;
  logic        fb;

  // lsb-first reflected register; the 5-bit form lives in the low bits
  always_comb begin
    crc_d = crc_q;
    fb    = crc_q[0] ^ i_bit;
    if (i_load) begin
      crc_d = i_crc5 ? {11'h000, i_preset[4:0]} : i_preset;
    end else if (i_bit_valid) begin
      if (i_crc5) begin
        crc_d = {11'h000, 1'b0, crc_q[4:1]} ^ (fb ? {11'h000, `POLY5_REFL} : 16'h0000);
      end else begin
        crc_d = {1'b0, crc_q[15:1]} ^ (fb ? `POLY16_REFL : 16'h0000);
      end
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      crc_q <= 16'h0000;
    end else begin
      crc_q <= crc_d;
    end
  end

  assign o_crc = crc_q;

endmodule // rx_crc_engine
`default_nettype wire

// ---- verilog/rx_irq_ctrl.sv ----
`default_nettype none
`include "rx_frame_check_params.svh"
module rx_irq_ctrl
  import rx_frame_check_pkg::*;
(
  input  wire logic       clk,
  input  wire logic       rst,
  input  wire logic [3:0] i_event,
  input  wire logic [3:0] i_clear,
  input  wire logic       i_mask_wr,
  input  wire logic [3:0] i_mask,
  output logic      [3:0] o_status,
  output logic      [3:0] o_mask,
  output logic            o_irq
);

  logic [3:0] stat_q;
  logic [3:0] stat_d;
  logic [3:0] mask_q;
  logic [3:0] mask_d;
  logic       irq_q;
  logic       irq_d;

  // an event in the clearing cycle survives the clear
  always_comb begin
    stat_d = (stat_q & ~i_clear) | i_event;
    mask_d = i_mask_wr ? i_mask : mask_q;
    irq_d  = |(stat_d & mask_d);
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      stat_q <= `IRQ_RESET;
      mask_q <= `IRQ_RESET;
      irq_q  <= 1'b0;
    end else begin
      stat_q <= stat_d;
      mask_q <= mask_d;
      irq_q  <= irq_d;
    end
  end

  assign o_status = stat_q;
  assign o_mask   = mask_q;
  assign o_irq    = irq_q;

endmodule // rx_irq_ctrl
`default_nettype wire

// ---- verilog/rx_frame_check_status.sv ----
// Contract
// - codes 100/101 load 0012h/E012h, 111 arbitrary
// - codes 000-011 presets; detector writes select code
// - type bit: clear 16-bit, set 5-bit
// - invert bit compares against residue F0B8h, or 18h in 5-bit form
// - detector clears invert for A/fast, sets B
// - enable checks CRC; detector sets for B/fast
// - bits 25:19 hold first collision position
// - collision position includes bit alignment offset
// - alignment gives first bit's position in byte
// - bit 18 set on any collision
// - bit 17 set on protocol error
// - protocol error stops reception immediately
// - error flags clear at next reception start
// - bit 16 on parity/CRC error, keep receiving
// - reversed parity stop: parity error not flagged
// - bits 15:13 valid bits of last byte
// - bits 12:9 count frames at receive interrupt
// - bits 8:0 byte count of the last frame
`default_nettype none
`include "rx_frame_check_params.svh"
module rx_frame_check_status
  import rx_frame_check_pkg::*;
(
  input  wire logic        I_SYS_CLK,
  input  wire logic        I_RST,
  input  wire logic        I_WB_CYC,
  input  wire logic        I_WB_STB,
  input  wire logic        I_WB_WE,
  input  wire logic [7:0]  I_WB_ADR,
  input  wire logic [3:0]  I_WB_SEL,
  input  wire logic [31:0] I_WB_DAT,
  output logic      [31:0] O_WB_DAT,
  output logic             O_WB_ACK,
  input  wire logic        I_RX_ENABLE,
  input  wire logic        I_RX_START,
  input  wire rx_bit_t     I_RX_BIT,
  input  wire logic        I_RX_PARITY_ERR,
  input  wire logic        I_RX_PROTOCOL_ERR,
  input  wire logic        I_RX_END,
  input  wire logic        I_MODE_DET_VALID,
  input  wire mode_t       I_MODE_DET_TYPE,
  output logic             O_RX_STOP,
  output logic             O_IRQ
);

  ////////////////////////////////////////////////////////////////////////////
  // helpers

  function automatic logic [31:0] apply_sel(input logic [31:0] old_v,
                                            input logic [31:0] new_v,
                                            input logic [3:0]  sel);
    logic [31:0] res;
    res = old_v;
    for (int b = 0; b < 4; b++) begin
      if (sel[b]) begin
        res[b*8 +: 8] = new_v[b*8 +: 8];
      end
    end
    return res;
  endfunction

  function automatic logic [15:0] preset_of(input crc_cfg_t c);
    logic [15:0] p;
    unique case (c.preset_sel)
      3'h0: p = `PRESET_000;
      3'h1: p = `PRESET_001;
      3'h2: p = `PRESET_010;
      3'h3: p = `PRESET_011;
      3'h4: p = `PRESET_100;
      3'h5: p = `PRESET_101;
      3'h6: p = `PRESET_000;
      3'h7: p = c.preset_value;
    endcase
    // 5-bit calculation only looks at the low byte
    if (c.crc5) begin
      p = {8'h00, p[7:0]};
    end
    return p;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // bus decode

  logic        acc;
  logic        wr;
  logic [5:0]  idx;
  logic        ack_q;
  logic        ack_d;
  logic [31:0] rdat_q;
  logic [31:0] rdat_d;

  assign acc = I_WB_CYC & I_WB_STB & ~ack_q;
  assign wr  = acc & I_WB_WE;
  assign idx = I_WB_ADR[7:2];

  ////////////////////////////////////////////////////////////////////////////
  // configuration and control registers

  crc_cfg_t   cfg_q;
  crc_cfg_t   cfg_d;
  logic [1:0] ctrl_q;
  logic [1:0] ctrl_d;
  logic [31:0] ctrl_w;

  always_comb begin
    cfg_d  = cfg_q;
    ctrl_d = ctrl_q;
    ctrl_w = apply_sel({30'h0, ctrl_q}, I_WB_DAT, I_WB_SEL);
    if (wr && idx == `IDX_CRC_CFG) begin
      cfg_d = crc_cfg_t'(apply_sel(cfg_q, I_WB_DAT, I_WB_SEL) & `CFG_WMASK);
    end
    if (wr && idx == `IDX_RX_CTRL) begin
      ctrl_d = ctrl_w[1:0];
    end
    // detector result beats a software write in the same cycle
    if (I_MODE_DET_VALID) begin
      unique case (I_MODE_DET_TYPE)
        MODE_TYPE_A: begin
          cfg_d.preset_sel   = 3'h1;
          cfg_d.check_invert = 1'b0;
          cfg_d.parity_en    = 1'b1;
          cfg_d.parity_odd   = 1'b1;
        end
        MODE_TYPE_B: begin
          cfg_d.preset_sel   = 3'h3;
          cfg_d.check_invert = 1'b1;
          cfg_d.check_en     = 1'b1;
        end
        MODE_FAST: begin
          cfg_d.preset_sel   = 3'h0;
          cfg_d.check_invert = 1'b0;
          cfg_d.check_en     = 1'b1;
        end
        default: begin
          cfg_d = cfg_q;
        end
      endcase
    end
  end

  always_ff @(posedge I_SYS_CLK) begin
    if (I_RST) begin
      cfg_q  <= crc_cfg_t'(`CFG_RESET);
      ctrl_q <= `CTRL_RESET;
    end else begin
      cfg_q  <= cfg_d;
      ctrl_q <= ctrl_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // crc engine

  logic [15:0] crc;
  logic        crc_load;
  logic        bit_take;
  rx_state_t   st_q;
  rx_state_t   st_d;

  assign crc_load = I_RX_START;
  assign bit_take = I_RX_BIT.valid & (st_q == ST_RECV) & ~I_RX_START;

  rx_crc_engine u_crc (
    .clk         (I_SYS_CLK),
    .rst         (I_RST),
    .i_load      (crc_load),
    .i_preset    (preset_of(cfg_q)),
    .i_crc5      (cfg_q.crc5),
    .i_bit_valid (bit_take),
    .i_bit       (I_RX_BIT.data),
    .o_crc       (crc)
  );

  logic crc_bad;

  always_comb begin
    if (cfg_q.crc5) begin
      crc_bad = crc[4:0] != (cfg_q.check_invert ? `RESIDUE5_INV : 5'h00);
    end else begin
      crc_bad = crc != (cfg_q.check_invert ? `RESIDUE16_INV : 16'h0000);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // reception tracking

  logic [11:0] pos_q;
  logic [11:0] pos_d;
  logic        seen_q;
  logic        seen_d;
  logic [6:0]  cpos_q;
  logic [6:0]  cpos_d;
  logic        coll_q;
  logic        coll_d;
  logic        perr_q;
  logic        perr_d;
  logic        derr_q;
  logic        derr_d;
  logic [8:0]  bytes_q;
  logic [8:0]  bytes_d;
  logic [2:0]  last_q;
  logic [2:0]  last_d;
  logic [3:0]  frames_q;
  logic [3:0]  frames_d;
  logic        stop_q;
  logic        stop_d;
  logic [3:0]  ev;
  logic        finish;

  always_comb begin
    st_d     = st_q;
    pos_d    = pos_q;
    seen_d   = seen_q;
    cpos_d   = cpos_q;
    coll_d   = coll_q;
    perr_d   = perr_q;
    derr_d   = derr_q;
    bytes_d  = bytes_q;
    last_d   = last_q;
    frames_d = frames_q;
    stop_d   = 1'b0;
    ev       = 4'h0;
    finish   = 1'b0;
    if (I_RX_ENABLE) begin
      frames_d = 4'h0;
    end
    if (I_RX_START) begin
      st_d   = ST_RECV;
      pos_d  = {9'h000, cfg_q.bit_align};
      seen_d = 1'b0;
      cpos_d = 7'h00;
      coll_d = 1'b0;
      perr_d = 1'b0;
      derr_d = 1'b0;
      if (!ctrl_q[`CTRL_BIT_MULTI]) begin
        frames_d = 4'h0;
      end
    end else if (st_q == ST_RECV) begin
      if (bit_take) begin
        // position counts data bits only, offset by the alignment
        if (I_RX_BIT.coll) begin
          coll_d = 1'b1;
          if (!seen_q) begin
            seen_d = 1'b1;
            ev[`IRQ_BIT_COLL] = 1'b1;
            cpos_d = (pos_q > `COLL_POS_MAX) ? 7'h7f : pos_q[6:0];
          end
        end
        if (pos_q != 12'hfff) begin
          pos_d = pos_q + 12'h001;
        end
      end
      if (I_RX_PARITY_ERR && cfg_q.parity_en && !ctrl_q[`CTRL_BIT_REVPAR]) begin
        derr_d = 1'b1;
      end
      if (I_RX_PROTOCOL_ERR) begin
        perr_d = 1'b1;
        stop_d = 1'b1;
        ev[`IRQ_BIT_PROTO] = 1'b1;
        finish = 1'b1;
      end else if (I_RX_END) begin
        finish = 1'b1;
        if (cfg_q.check_en && crc_bad) begin
          derr_d = 1'b1;
        end
      end
      if (finish) begin
        st_d    = ST_IDLE;
        // partial last byte rounds the byte count up
        bytes_d = pos_q[11:3] + {8'h00, |pos_q[2:0]};
        last_d  = pos_q[2:0];
        frames_d = frames_d + 4'h1;
        ev[`IRQ_BIT_DONE] = 1'b1;
      end
    end
    if (derr_d && !derr_q) begin
      ev[`IRQ_BIT_INTEG] = 1'b1;
    end
  end

  always_ff @(posedge I_SYS_CLK) begin
    if (I_RST) begin
      st_q     <= ST_IDLE;
      pos_q    <= 12'h000;
      seen_q   <= 1'b0;
      cpos_q   <= 7'h00;
      coll_q   <= 1'b0;
      perr_q   <= 1'b0;
      derr_q   <= 1'b0;
      bytes_q  <= 9'h000;
      last_q   <= 3'h0;
      frames_q <= 4'h0;
      stop_q   <= 1'b0;
    end else begin
      st_q     <= st_d;
      pos_q    <= pos_d;
      seen_q   <= seen_d;
      cpos_q   <= cpos_d;
      coll_q   <= coll_d;
      perr_q   <= perr_d;
      derr_q   <= derr_d;
      bytes_q  <= bytes_d;
      last_q   <= last_d;
      frames_q <= frames_d;
      stop_q   <= stop_d;
    end
  end

  rx_status_t status;

  always_comb begin
    status                          = rx_status_t'(`STATUS_RESET);
    status.first_collision_position = cpos_q;
    status.collision                = coll_q;
    status.protocol_err             = perr_q;
    status.integrity_err            = derr_q;
    status.last_bits                = last_q;
    status.frames                   = frames_q;
    status.bytes                    = bytes_q;
  end

  ////////////////////////////////////////////////////////////////////////////
  // interrupts

  logic [3:0]  irq_stat;
  logic [3:0]  irq_mask;
  logic [31:0] clr_w;
  logic [31:0] mask_w;

  assign clr_w  = apply_sel(32'h0, I_WB_DAT, I_WB_SEL);
  assign mask_w = apply_sel({28'h0, irq_mask}, I_WB_DAT, I_WB_SEL);

  rx_irq_ctrl u_irq (
    .clk       (I_SYS_CLK),
    .rst       (I_RST),
    .i_event   (ev),
    .i_clear   ((wr && idx == `IDX_IRQ_STATUS) ? clr_w[3:0] : 4'h0),
    .i_mask_wr (wr && idx == `IDX_IRQ_MASK),
    .i_mask    (mask_w[3:0]),
    .o_status  (irq_stat),
    .o_mask    (irq_mask),
    .o_irq     (O_IRQ)
  );

  ////////////////////////////////////////////////////////////////////////////
  // read path and acknowledge

  always_comb begin
    ack_d  = acc;
    rdat_d = rdat_q;
    if (acc) begin
      unique case (idx)
        `IDX_CRC_CFG:    rdat_d = cfg_q;
        `IDX_RX_STATUS:  rdat_d = status;
        `IDX_IRQ_STATUS: rdat_d = {28'h0, irq_stat};
        `IDX_IRQ_MASK:   rdat_d = {28'h0, irq_mask};
        `IDX_RX_CTRL:    rdat_d = {30'h0, ctrl_q};
        default:         rdat_d = 32'h0;
      endcase
    end
  end

  always_ff @(posedge I_SYS_CLK) begin
    if (I_RST) begin
      ack_q  <= 1'b0;
      rdat_q <= 32'h0;
    end else begin
      ack_q  <= ack_d;
      rdat_q <= rdat_d;
    end
  end

  assign O_WB_ACK  = ack_q;
  assign O_WB_DAT  = rdat_q;
  assign O_RX_STOP = stop_q;

endmodule // rx_frame_check_status
`default_nettype wire

// ---- bench/rx_frame_check_chk.sv ----
`default_nettype none
module rx_frame_check_chk
  import rx_frame_check_pkg::*;
(
  input wire logic        I_SYS_CLK,
  input wire logic        I_RST,
  input wire logic        I_WB_CYC,
  input wire logic        I_WB_STB,
  input wire logic        I_WB_WE,
  input wire logic [7:0]  I_WB_ADR,
  input wire logic [31:0] O_WB_DAT,
  input wire logic        O_WB_ACK,
  input wire logic        I_RX_START,
  input wire logic        I_RX_END,
  input wire logic        I_RX_PROTOCOL_ERR,
  input wire logic        O_RX_STOP,
  input wire logic        O_IRQ
);
  timeunit 1ns;
  timeprecision 100ps;
  logic       req;
  logic       rcv_d;
  logic       rcv_q;
  logic       st_q;
  logic       unm_q;
  logic [5:0] idx;
  default clocking @(posedge I_SYS_CLK); endclocking
  default disable iff (I_RST);
  assign req = I_WB_CYC && I_WB_STB && !O_WB_ACK;
  assign idx = I_WB_ADR[7:2];
  // start wins over end or error in the same cycle
  always_comb begin
    rcv_d = rcv_q;
    if (I_RX_END || I_RX_PROTOCOL_ERR) rcv_d = 1'b0;
    if (I_RX_START) rcv_d = 1'b1;
  end
  always_ff @(posedge I_SYS_CLK) begin
    rcv_q <= I_RST ? 1'b0 : rcv_d;
    st_q  <= req && !I_WB_WE && idx == 6'h13;
    unm_q <= req && !I_WB_WE && !(idx inside {6'h12, 6'h13, 6'h20, 6'h21, 6'h22});
  end
  ////////////////////////////////////////////////////////////
  ack_pulse_a: assert property (O_WB_ACK |=> !O_WB_ACK)
    else $error("ack held longer than one cycle");
  ack_answer_a: assert property (req |=> O_WB_ACK)
    else $error("request not acknowledged");
  ack_cause_a: assert property (O_WB_ACK |-> $past(I_WB_CYC) && $past(I_WB_STB))
    else $error("ack without request");
  stop_cause_a: assert property (O_RX_STOP |-> $past(I_RX_PROTOCOL_ERR) && $past(rcv_q))
    else $error("stop without protocol error");
  proto_stop_a: assert property (rcv_q && I_RX_PROTOCOL_ERR && !I_RX_START |=> O_RX_STOP ##1 !O_RX_STOP)
    else $error("protocol error did not stop reception");
  status_upper_a: assert property (O_WB_ACK && st_q |-> O_WB_DAT[31:26] == 6'h00)
    else $error("status reserved bits not zero");
  unmapped_zero_a: assert property (O_WB_ACK && unm_q |-> O_WB_DAT == 32'h0)
    else $error("unmapped read not zero");
  reset_quiet_a: assert property (disable iff (1'b0) I_RST |=> !O_WB_ACK && !O_IRQ && !O_RX_STOP && O_WB_DAT == 32'h0)
    else $error("outputs not quiet after reset");
endmodule // rx_frame_check_chk
`default_nettype wire

// ---- bench/rx_demod_model.sv ----
`default_nettype none
module rx_demod_model
  import rx_frame_check_pkg::*;
(
  input  wire logic     i_clk,
  output var rx_bit_t   o_bit,
  output var logic      o_start,
  output var logic      o_end,
  output var logic      o_perr,
  output var logic      o_proto
);
  timeunit 1ns;
  timeprecision 100ps;
  initial begin
    o_bit = 3'b010;
    o_start = 1'b0;
    o_end = 1'b0;
    o_perr = 1'b0;
    o_proto = 1'b0;
  end
  // gap data shows the inverse; the trailing idle cycle inverts whatever data is then on the line
  task automatic frame(input int nb, input logic [31:0] pat, input int coll, err, kind, gap);
    @(posedge i_clk);
    o_start <= 1'b1;
    for (int i = 0; i < nb; i++) begin
      @(posedge i_clk);
      o_start <= 1'b0;
      o_perr <= i == err && kind == 1;
      o_proto <= i == err && kind == 2;
      o_bit <= {!(i == err && kind == 2), pat[i], i == coll};
      repeat (gap) begin
        @(posedge i_clk);
        o_perr <= 1'b0;
        o_proto <= 1'b0;
        o_bit <= {1'b0, ~pat[i], 1'b0};
      end
    end
    @(posedge i_clk);
    o_start <= 1'b0;
    o_perr <= 1'b0;
    o_proto <= 1'b0;
    o_bit <= {1'b0, ~o_bit.data, 1'b0};
    @(posedge i_clk);
    o_end <= 1'b1;
    @(posedge i_clk);
    o_end <= 1'b0;
  endtask
endmodule // rx_demod_model
`default_nettype wire

// ---- bench/rx_frame_check_status_test.sv ----
`default_nettype none
module rx_frame_check_status_test import rx_frame_check_pkg::*;;
  timeunit 1ns;
  timeprecision 100ps;
  typedef struct {
    logic [31:0] cfg;
    logic [1:0]  ctrl;
    int          nb, coll, err, kind, gap;
    logic [31:0] pat, exp;
  } row_t;
  typedef struct {logic [31:0] pre; mode_t ty; logic [31:0] exp, msk;} det_t;
  logic        clk = 0, rst = 1, cyc = 0, stb = 0, we = 0, en = 0, dv = 0;
  logic        ack, irq, stop, start, rend, perr, proto;
  logic [7:0]  adr = 8'h00;
  logic [3:0]  sel = 4'hf;
  logic [31:0] wdat = 32'h0, rdat, q;
  mode_t       dty = MODE_TYPE_A;
  rx_bit_t     rbit;
  int          n_errors = 0, compares = 0;

  rx_frame_check_status dut_u (.I_SYS_CLK(clk), .I_RST(rst), .I_WB_CYC(cyc), .I_WB_STB(stb),
    .I_WB_WE(we), .I_WB_ADR(adr), .I_WB_SEL(sel), .I_WB_DAT(wdat), .O_WB_DAT(rdat),
    .O_WB_ACK(ack), .I_RX_ENABLE(en), .I_RX_START(start), .I_RX_BIT(rbit),
    .I_RX_PARITY_ERR(perr), .I_RX_PROTOCOL_ERR(proto), .I_RX_END(rend),
    .I_MODE_DET_VALID(dv), .I_MODE_DET_TYPE(dty), .O_RX_STOP(stop), .O_IRQ(irq));
  rx_demod_model mdl_u (.i_clk(clk), .o_bit(rbit), .o_start(start), .o_end(rend),
    .o_perr(perr), .o_proto(proto));

  always #2 clk = ~clk;
  ////////////////////////////////////////////////////////////
  task automatic stop_test;
    if (n_errors == 0 && compares > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  task automatic cmp(input logic [31:0] g, e);
    compares++;
    if (g !== e) begin
      n_errors++;
      $display("[FAIL] %0t got %h expected %h", $time, g, e);
    end
  endtask
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n = 0;
    @(posedge clk);
    cyc <= 1; stb <= 1; we <= w; adr <= a; wdat <= d;
    do begin
      @(posedge clk);
      n++;
    end while (ack !== 1'b1 && n < 40);
    q = rdat;
    cyc <= 0; stb <= 0;
    if (n >= 40) begin
      n_errors++;
      stop_test();
    end
  endtask
  task automatic rd_chk(input logic [7:0] a, input logic [31:0] e, m);
    wb(1'b0, a, 32'h0);
    cmp(q & m, e);
  endtask
  task automatic frame_chk(input row_t r);
    wb(1'b1, 8'h48, r.cfg);
    wb(1'b1, 8'h88, {30'h0, r.ctrl});
    mdl_u.frame(r.nb, r.pat, r.coll, r.err, r.kind, r.gap);
    rd_chk(8'h4c, r.exp, 32'hffffffff);
  endtask
  // bench-side reflected crc, lsb first
  function automatic logic [15:0] crc16(input logic [15:0] c, input logic [7:0] d);
    for (int i = 0; i < 8; i++) c = (c[0] ^ d[i]) ? (c >> 1) ^ 16'h8408 : c >> 1;
    return c;
  endfunction
  // 5-bit form, same lsb-first shifting
  function automatic logic [4:0] crc5(input logic [4:0] c, input logic [7:0] d);
    for (int i = 0; i < 8; i++) c = (c[0] ^ d[i]) ? (c >> 1) ^ 5'h12 : c >> 1;
    return c;
  endfunction

  initial begin
    logic [15:0] c;
    logic [4:0]  c5;
    logic [15:0] pre [8] = '{16'h0000, 16'h6363, 16'ha671, 16'hffff,
                             16'h0012, 16'he012, 16'h0000, 16'h1234};
    logic [7:0]  regs [5] = '{8'h48, 8'h4c, 8'h80, 8'h84, 8'h88};
    row_t rows [10] = '{
      '{32'h0, 2'h0, 13, -1, -1, 0, 0, 32'h5a5, 32'h0000a202},
      '{32'hc0, 2'h0, 13, 4, -1, 0, 2, 32'h5a5, 32'h003c0202},
      '{32'h0, 2'h0, 8, 0, -1, 0, 0, 32'h0, 32'h00040201},
      '{32'h1, 2'h0, 16, -1, -1, 0, 0, 32'h0, 32'h00000202},
      '{32'h3, 2'h0, 16, -1, -1, 0, 0, 32'h0, 32'h00010202},
      '{32'h5, 2'h0, 8, -1, -1, 0, 0, 32'h0, 32'h00000201},
      '{32'h400, 2'h0, 16, -1, 5, 1, 0, 32'hff, 32'h00010202},
      '{32'h400, 2'h2, 16, -1, 5, 1, 0, 32'hff, 32'h00000202},
      '{32'h0, 2'h0, 16, -1, 3, 2, 0, 32'hff, 32'h00026201},
      '{32'h0, 2'h0, 13, -1, -1, 0, 1, 32'h5a5, 32'h0000a202}};
    det_t dets [4] = '{'{32'h2, MODE_TYPE_A, 32'hc08, 32'hfffffffe},
                       '{32'h0, MODE_TYPE_B, 32'h1b, 32'hfffff3ff},
                       '{32'h1a, MODE_FAST, 32'h1, 32'hfffff3ff},
                       '{32'h1a, mode_t'(2'h3), 32'h1a, 32'hffffffff}};
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    foreach (regs[i]) rd_chk(regs[i], 32'h0, 32'hffffffff);
    wb(1'b1, 8'h4c, 32'hffffffff);
    wb(1'b1, 8'h40, 32'hffffffff);
    wb(1'b1, 8'h48, 32'hffffffff);
    rd_chk(8'h4c, 32'h0, 32'hffffffff);
    rd_chk(8'h40, 32'h0, 32'hffffffff);
    rd_chk(8'h48, 32'hffff0fff, 32'hffffffff);
    foreach (rows[i]) frame_chk(rows[i]);
    // each preset code, 111 with its arbitrary value too, must leave a clean residue with no integrity flag
    foreach (pre[i]) begin
      c = crc16(pre[i], 8'ha5);
      frame_chk('{{16'h1234, 10'h0, i[2:0], 3'h1}, 2'h0, 24, -1, -1, 0, 0,
                  {8'h0, c, 8'ha5}, 32'h203});
    end
    // inverted crc appended must land on the fixed residue
    c = crc16(16'hffff, 8'ha5);
    frame_chk('{32'h1b, 2'h0, 24, -1, -1, 0, 0, {8'h0, ~c, 8'ha5}, 32'h203});
    // 5-bit form seeded from the low bits of the arbitrary preset
    c5 = crc5(5'h14, 8'ha5);
    frame_chk('{32'h1234003d, 2'h0, 13, -1, -1, 0, 0, {19'h0, c5, 8'ha5}, 32'ha202});
    foreach (dets[i]) begin
      wb(1'b1, 8'h48, dets[i].pre);
      @(posedge clk);
      dv <= 1'b1;
      dty <= dets[i].ty;
      @(posedge clk);
      dv <= 1'b0;
      rd_chk(8'h48, dets[i].exp, dets[i].msk);
    end
    // upper lanes only: low half must keep its value
    sel <= 4'hc;
    wb(1'b1, 8'h48, 32'h5a5a_ffff);
    sel <= 4'hf;
    rd_chk(8'h48, 32'h5a5a_001a, 32'hffffffff);
    rd_chk(8'h80, 32'hf, 32'hffffffff);
    @(negedge clk) cmp({31'h0, irq}, 32'h0);
    wb(1'b1, 8'h84, 32'h1);
    repeat (2) @(posedge clk);
    @(negedge clk) cmp({31'h0, irq}, 32'h1);
    wb(1'b1, 8'h80, 32'h1);
    repeat (2) @(posedge clk);
    @(negedge clk) cmp({31'h0, irq}, 32'h0);
    rd_chk(8'h80, 32'he, 32'hffffffff);
    wb(1'b1, 8'h88, 32'h1);
    @(posedge clk) en <= 1'b1;
    @(posedge clk) en <= 1'b0;
    mdl_u.frame(8, 32'h0, -1, -1, 0, 0);
    mdl_u.frame(8, 32'h0, -1, -1, 0, 0);
    rd_chk(8'h4c, 32'h401, 32'hffffffff);
    // mid-run reset while the interrupt line is high
    rst <= 1'b1;
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    @(negedge clk) cmp({31'h0, irq}, 32'h0);
    foreach (regs[i]) rd_chk(regs[i], 32'h0, 32'hffffffff);
    stop_test();
  end
endmodule // rx_frame_check_status_test

bind rx_frame_check_status rx_frame_check_chk chk_u (.I_SYS_CLK(I_SYS_CLK), .I_RST(I_RST),
  .I_WB_CYC(I_WB_CYC), .I_WB_STB(I_WB_STB), .I_WB_WE(I_WB_WE), .I_WB_ADR(I_WB_ADR),
  .O_WB_DAT(O_WB_DAT), .O_WB_ACK(O_WB_ACK), .I_RX_START(I_RX_START), .I_RX_END(I_RX_END),
  .I_RX_PROTOCOL_ERR(I_RX_PROTOCOL_ERR), .O_RX_STOP(O_RX_STOP), .O_IRQ(O_IRQ));
`default_nettype wire
